// ===== core/chamber_pkg.sv
package chamber_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 200_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_57600 = 57600;
  localparam int BAUD_115200 = 115200;

  // ==========================================================
  // Register numbers: low word of each 32-bit pair, or the single word
  localparam logic [15:0] REG_TEMP_SP = 16'h0ade;
  localparam logic [15:0] REG_RAMP_ACTION = 16'h0aea;
  localparam logic [15:0] REG_RAMP_SCALE = 16'h0aec;
  localparam logic [15:0] REG_RAMP_RATE = 16'h0aee;
  localparam logic [15:0] REG_TEMP_WSP = 16'h0afa;
  localparam logic [15:0] REG_HUM_SP = 16'h0b7e;
  localparam logic [15:0] REG_HUM_WSP = 16'h0b9a;
  localparam logic [15:0] REG_MEAS_TEMP = 16'h6bc2;
  localparam logic [15:0] REG_MEAS_HUM = 16'h70ea;
  localparam logic [6:0][15:0] REG_EVENT = {16'h41ba, 16'h41b8, 16'h41b6,
                                            16'h40d8, 16'h40d6, 16'h40d4, 16'h40d2};

  // ==========================================================
  // Value codes
  localparam logic [15:0] EVT_OFF = 16'h003e;
  localparam logic [15:0] EVT_ON = 16'h003f;
  localparam logic [15:0] ACT_OFF = 16'h003e;
  localparam logic [15:0] ACT_STARTUP = 16'h0058;
  localparam logic [15:0] ACT_SETPOINT = 16'h0055;
  localparam logic [15:0] ACT_BOTH = 16'h000d;
  localparam logic [15:0] SCALE_MINUTE = 16'h0039;
  localparam logic [15:0] SCALE_HOUR = 16'h0027;
  localparam logic [31:0] FLOAT_RESET = 32'h0000_0000;

  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

  // ==========================================================
  // Communication settings and factory values
  localparam logic [1:0] MAP_NATIVE = 2'h1;
  localparam logic [1:0] MAP_LEGACY = 2'h2;
  localparam logic [7:0] STATION_DEFAULT = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hf7;
  localparam logic [31:0] IP_ADDR_DEFAULT = 32'hc0a8_00de;
  localparam logic [31:0] IP_MASK_DEFAULT = 32'hffff_ff00;
  localparam logic [31:0] IP_GW_DEFAULT = 32'h0000_0000;

  typedef enum logic [2:0] {
    BAUD_SEL_9600 = 3'h0, BAUD_SEL_19200 = 3'h1, BAUD_SEL_38400 = 3'h2,
    BAUD_SEL_57600 = 3'h3, BAUD_SEL_115200 = 3'h4
  } baud_t;
  typedef enum logic [1:0] {PARITY_NONE = 2'h0, PARITY_EVEN = 2'h1, PARITY_ODD = 2'h2} parity_t;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h0, SEL_TEMP_SP = 4'h1, SEL_RAMP_ACTION = 4'h2, SEL_RAMP_SCALE = 4'h3,
    SEL_RAMP_RATE = 4'h4, SEL_TEMP_WSP = 4'h5, SEL_HUM_SP = 4'h6, SEL_HUM_WSP = 4'h7,
    SEL_EVENT = 4'h8, SEL_MEAS_TEMP = 4'h9, SEL_MEAS_HUM = 4'ha
  } reg_sel_t;

endpackage

// ===== core/baud_tick.sv
`timescale 1ns/100ps
module baud_tick import chamber_pkg::*; #(
  parameter int CLK_RATE = CLK_HZ
) (
  input wire logic clock,
  input wire logic srst,
  input wire baud_t baud_sel,
  output logic tick
);

  // ==========================================================
  // Oversampling enable for the serial port
  function automatic logic [15:0] div_of(input baud_t sel);
    case (sel)
      BAUD_SEL_19200: div_of = 16'(CLK_RATE / (OVERSAMPLE * BAUD_19200) - 1);
      BAUD_SEL_38400: div_of = 16'(CLK_RATE / (OVERSAMPLE * BAUD_38400) - 1);
      BAUD_SEL_57600: div_of = 16'(CLK_RATE / (OVERSAMPLE * BAUD_57600) - 1);
      BAUD_SEL_115200: div_of = 16'(CLK_RATE / (OVERSAMPLE * BAUD_115200) - 1);
      default: div_of = 16'(CLK_RATE / (OVERSAMPLE * BAUD_9600) - 1);
    endcase
  endfunction

  if (CLK_RATE / (OVERSAMPLE * BAUD_115200) < 2 || CLK_RATE / (OVERSAMPLE * BAUD_9600) > 65535)
    $error("baud_tick: clock rate cannot serve the baud table");

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_t;

  tick_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= div_of(baud_sel)) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign tick = s_r.tick;

endmodule // baud_tick

// ===== core/word_mux.sv
`timescale 1ns/100ps
module word_mux (
  input wire logic [31:0] value,
  input wire logic half,
  input wire logic word_low,
  input wire logic [15:0] wdata,
  output logic [15:0] rd_word,
  output logic [31:0] merged
);

  // ==========================================================
  // Word order: half 0 is the lower register number
  logic upper;

  assign upper = half ^ word_low;
  assign rd_word = upper ? value[31:16] : value[15:0];
  assign merged = upper ? {wdata, value[15:0]} : {value[31:16], wdata};

endmodule // word_mux

// ===== core/chamber_modbus_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - Every register is one 16-bit word on the request port.
// - A 32-bit value spans register N (low) and N+1 (high).
// - Default order puts the two low bytes in the lower-numbered word.
// - Word order Low swaps which register word carries the upper half.
// - Data map 1 serves the native set; map 2 serves no register at all.
// - Communication settings load only at reset, never while running.
// - Station address defaults to 1; valid range 1 to 247.
// - Seven event words, read/write, 62 means off and 63 on.
// - Working set point reads the ramp value while a ramp runs.
// - Set points are read/write floats; measured values are read-only.
// - Ramp action codes: off 62, startup 88, set point 85, both 13.
// - Ramp scale codes: per minute 57, per hour 39; rate follows.
// - Network defaults DHCP, 192.168.0.222, 255.255.255.0, 0.0.0.0.
// - TCP access is on by default and can be switched off.
// - Requests carry station, function code and data per register.
module chamber_modbus_regs import chamber_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic nv_valid,
  input wire logic [1:0] nv_data_map,
  input wire logic nv_word_low,
  input wire logic [7:0] nv_station,
  input wire baud_t nv_baud,
  input wire parity_t nv_parity,
  input wire logic nv_ip_fixed,
  input wire logic nv_tcp_enable,
  input wire logic [31:0] nv_ip_addr,
  input wire logic [31:0] nv_ip_mask,
  input wire logic [31:0] nv_ip_gateway,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_tcp,
  input wire logic [7:0] req_station,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_reg,
  input wire logic [15:0] req_wdata,
  output logic resp_valid,
  output logic resp_exception,
  output logic [7:0] resp_func,
  output logic [15:0] resp_data,
  input wire logic [31:0] meas_temp,
  input wire logic [31:0] meas_hum,
  input wire logic [31:0] work_temp,
  input wire logic [31:0] work_hum,
  input wire logic ramp_active,
  output logic [31:0] temperature_setpoint,
  output logic [31:0] humidity_setpoint,
  output logic [15:0] temp_ramp_action,
  output logic [15:0] temp_ramp_scale,
  output logic [31:0] temp_ramp_rate,
  output logic [6:0] event_on,
  output logic [1:0] live_data_map,
  output logic live_word_low,
  output logic [7:0] live_station,
  output baud_t live_baud,
  output parity_t live_parity,
  output logic network_addressing_choice,
  output logic live_tcp_enable,
  output logic [31:0] live_ip_addr,
  output logic [31:0] live_ip_mask,
  output logic [31:0] live_ip_gateway,
  output logic baud_en
);

  // ==========================================================
  // State
  typedef struct packed {
    logic cfg_pending;
    logic [1:0] data_map;
    logic word_low;
    logic [7:0] station;
    baud_t baud;
    parity_t parity;
    logic ip_fixed;
    logic tcp_en;
    logic [31:0] ip_addr;
    logic [31:0] ip_mask;
    logic [31:0] ip_gw;
    logic [31:0] sp_temp;
    logic [31:0] sp_hum;
    logic [31:0] rate;
    logic [15:0] action;
    logic [15:0] scale;
    logic [6:0][15:0] evt;
    logic resp_valid;
    logic resp_exc;
    logic [7:0] resp_func;
    logic [15:0] resp_data;
  } regs_t;

  typedef struct packed {
    reg_sel_t sel;
    logic half;
    logic [2:0] evt;
  } dec_t;

  regs_t s_r, s_nxt;

  // ==========================================================
  // Register number decode, native map only
  function automatic dec_t decode(input logic [15:0] num, input logic [1:0] map);
    dec_t d;
    logic [15:0] pair;
    d.sel = SEL_NONE;
    d.half = num[0];
    d.evt = 3'h0;
    pair = {num[15:1], 1'b0};
    if (map == MAP_NATIVE) begin
      if (pair == REG_TEMP_SP) d.sel = SEL_TEMP_SP;
      else if (pair == REG_RAMP_RATE) d.sel = SEL_RAMP_RATE;
      else if (pair == REG_TEMP_WSP) d.sel = SEL_TEMP_WSP;
      else if (pair == REG_HUM_SP) d.sel = SEL_HUM_SP;
      else if (pair == REG_HUM_WSP) d.sel = SEL_HUM_WSP;
      else if (pair == REG_MEAS_TEMP) d.sel = SEL_MEAS_TEMP;
      else if (pair == REG_MEAS_HUM) d.sel = SEL_MEAS_HUM;
      else if (num == REG_RAMP_ACTION) d.sel = SEL_RAMP_ACTION;
      else if (num == REG_RAMP_SCALE) d.sel = SEL_RAMP_SCALE;
      for (int i = 0; i < 7; i++) begin
        if (num == REG_EVENT[i]) begin
          d.sel = SEL_EVENT;
          d.evt = 3'(i);
        end
      end
    end
    return d;
  endfunction

  function automatic logic action_ok(input logic [15:0] v);
    return v == ACT_OFF || v == ACT_STARTUP || v == ACT_SETPOINT || v == ACT_BOTH;
  endfunction

  function automatic logic events_ok(input logic [6:0][15:0] e);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 7; i++) ok = ok && (e[i] == EVT_ON || e[i] == EVT_OFF);
    return ok;
  endfunction

  // ==========================================================
  // Request decode and read path
  dec_t dec;
  logic accept;
  logic take;
  logic [31:0] val32;
  logic [15:0] val16;
  logic is_short;
  logic [15:0] pair_word;
  logic [31:0] merged;

  assign dec = decode(req_reg, s_r.data_map);
  // Serial requests need our station; TCP needs the port switched on
  assign accept = req_tcp ? s_r.tcp_en : (req_station == s_r.station);
  assign req_ready = !s_r.cfg_pending;
  assign take = req_valid && req_ready && accept;

  always_comb begin
    val32 = FLOAT_RESET;
    val16 = 16'h0000;
    is_short = 1'b0;
    case (dec.sel)
      SEL_TEMP_SP: val32 = s_r.sp_temp;
      SEL_HUM_SP: val32 = s_r.sp_hum;
      SEL_RAMP_RATE: val32 = s_r.rate;
      SEL_TEMP_WSP: val32 = ramp_active ? work_temp : s_r.sp_temp;
      SEL_HUM_WSP: val32 = ramp_active ? work_hum : s_r.sp_hum;
      SEL_MEAS_TEMP: val32 = meas_temp;
      SEL_MEAS_HUM: val32 = meas_hum;
      SEL_RAMP_ACTION: begin
        val16 = s_r.action;
        is_short = 1'b1;
      end
      SEL_RAMP_SCALE: begin
        val16 = s_r.scale;
        is_short = 1'b1;
      end
      SEL_EVENT: begin
        val16 = s_r.evt[dec.evt];
        is_short = 1'b1;
      end
      default: val32 = FLOAT_RESET;
    endcase
  end

  word_mux u_word_mux (
    .value(val32),
    .half(dec.half),
    .word_low(s_r.word_low),
    .wdata(req_wdata),
    .rd_word(pair_word),
    .merged(merged)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] exc;
    exc = EXC_NONE;
    s_nxt = s_r;
    s_nxt.resp_valid = 1'b0;
    if (s_r.cfg_pending) begin
      // Settings captured once after reset stand until the next reset
      s_nxt.cfg_pending = 1'b0;
      if (nv_valid) begin
        s_nxt.data_map = (nv_data_map == MAP_LEGACY) ? MAP_LEGACY : MAP_NATIVE;
        s_nxt.word_low = nv_word_low;
        s_nxt.station = (nv_station == 8'h00 || nv_station > STATION_MAX) ?
                        STATION_DEFAULT : nv_station;
        s_nxt.baud = nv_baud;
        s_nxt.parity = nv_parity;
        s_nxt.ip_fixed = nv_ip_fixed;
        s_nxt.tcp_en = nv_tcp_enable;
        s_nxt.ip_addr = nv_ip_addr;
        s_nxt.ip_mask = nv_ip_mask;
        s_nxt.ip_gw = nv_ip_gateway;
      end
    end else if (take) begin
      s_nxt.resp_valid = 1'b1;
      s_nxt.resp_exc = 1'b0;
      s_nxt.resp_func = req_func;
      s_nxt.resp_data = 16'h0000;
      if (req_func != FC_READ && req_func != FC_WRITE) begin
        exc = EXC_ILL_FUNC;
      end else if (dec.sel == SEL_NONE) begin
        exc = EXC_ILL_ADDR;
      end else if (req_func == FC_READ) begin
        s_nxt.resp_data = is_short ? val16 : pair_word;
      end else begin
        s_nxt.resp_data = req_wdata;
        case (dec.sel)
          SEL_TEMP_SP: s_nxt.sp_temp = merged;
          SEL_HUM_SP: s_nxt.sp_hum = merged;
          SEL_RAMP_RATE: s_nxt.rate = merged;
          SEL_RAMP_ACTION: begin
            if (action_ok(req_wdata)) s_nxt.action = req_wdata;
            else exc = EXC_ILL_VALUE;
          end
          SEL_RAMP_SCALE: begin
            if (req_wdata == SCALE_MINUTE || req_wdata == SCALE_HOUR) begin
              s_nxt.scale = req_wdata;
            end else begin
              exc = EXC_ILL_VALUE;
            end
          end
          SEL_EVENT: begin
            if (req_wdata == EVT_ON || req_wdata == EVT_OFF) begin
              s_nxt.evt[dec.evt] = req_wdata;
            end else begin
              exc = EXC_ILL_VALUE;
            end
          end
          // Working and measured values are read-only
          default: exc = EXC_ILL_ADDR;
        endcase
      end
      if (exc != EXC_NONE) begin
        s_nxt.resp_exc = 1'b1;
        s_nxt.resp_func = req_func | FC_EXC_FLAG;
        s_nxt.resp_data = {8'h00, exc};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
      s_r.cfg_pending <= 1'b1;
      s_r.data_map <= MAP_NATIVE;
      s_r.word_low <= 1'b0;
      s_r.station <= STATION_DEFAULT;
      s_r.baud <= BAUD_SEL_9600;
      s_r.parity <= PARITY_NONE;
      s_r.ip_fixed <= 1'b0;
      s_r.tcp_en <= 1'b1;
      s_r.ip_addr <= IP_ADDR_DEFAULT;
      s_r.ip_mask <= IP_MASK_DEFAULT;
      s_r.ip_gw <= IP_GW_DEFAULT;
      s_r.sp_temp <= FLOAT_RESET;
      s_r.sp_hum <= FLOAT_RESET;
      s_r.rate <= FLOAT_RESET;
      s_r.action <= ACT_OFF;
      s_r.scale <= SCALE_MINUTE;
      s_r.evt <= {7{EVT_OFF}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Serial rate enable
  baud_tick #(
    .CLK_RATE(CLK_HZ)
  ) u_baud_tick (
    .clock(clock),
    .srst(srst),
    .baud_sel(s_r.baud),
    .tick(baud_en)
  );

  // ==========================================================
  // Outputs
  assign resp_valid = s_r.resp_valid;
  assign resp_exception = s_r.resp_exc;
  assign resp_func = s_r.resp_func;
  assign resp_data = s_r.resp_data;
  assign temperature_setpoint = s_r.sp_temp;
  assign humidity_setpoint = s_r.sp_hum;
  assign temp_ramp_action = s_r.action;
  assign temp_ramp_scale = s_r.scale;
  assign temp_ramp_rate = s_r.rate;
  assign live_data_map = s_r.data_map;
  assign live_word_low = s_r.word_low;
  assign live_station = s_r.station;
  assign live_baud = s_r.baud;
  assign live_parity = s_r.parity;
  assign network_addressing_choice = s_r.ip_fixed;
  assign live_tcp_enable = s_r.tcp_en;
  assign live_ip_addr = s_r.ip_addr;
  assign live_ip_mask = s_r.ip_mask;
  assign live_ip_gateway = s_r.ip_gw;

  for (genvar g = 0; g < 7; g++) begin : g_evt
    assign event_on[g] = (s_r.evt[g] == EVT_ON);
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  AST_ONE_CYCLE_ANSWER: assert property (take |=> resp_valid)
    else $error("accepted request not answered on the next cycle");
  AST_NO_STRAY_ANSWER: assert property (!take |=> !resp_valid)
    else $error("answer raised without an accepted request");
  AST_UNMAPPED_EXC: assert property (take && dec.sel == SEL_NONE && req_func == FC_READ
    |=> resp_exception && resp_data == {8'h00, EXC_ILL_ADDR})
    else $error("unmapped register did not raise illegal address");
  AST_LEGACY_EMPTY: assert property (take && s_r.data_map == MAP_LEGACY
    |=> resp_exception)
    else $error("legacy map served a native register");
  AST_EVENT_CODES: assert property (events_ok(s_r.evt))
    else $error("event word holds a code other than on or off");
  AST_ACTION_CODES: assert property (action_ok(s_r.action))
    else $error("ramp action holds an illegal code");
  AST_SCALE_CODES: assert property (s_r.scale == SCALE_MINUTE || s_r.scale == SCALE_HOUR)
    else $error("ramp scale holds an illegal code");
  AST_STATION_RANGE: assert property (live_station != 8'h00 && live_station <= STATION_MAX)
    else $error("station address out of range");
  AST_CFG_FROZEN: assert property (!s_r.cfg_pending
    |=> $stable({live_data_map, live_word_low, live_station, live_tcp_enable}))
    else $error("communication setting changed while running");
  AST_TCP_OFF: assert property (req_valid && req_tcp && !live_tcp_enable |=> !resp_valid)
    else $error("TCP request answered while TCP is disabled");
  AST_WORD_ORDER: assert property (take && req_func == FC_WRITE && req_reg == REG_TEMP_SP
    && s_r.data_map == MAP_NATIVE |=> (live_word_low ? temperature_setpoint[31:16]
    : temperature_setpoint[15:0]) == $past(req_wdata))
    else $error("set point low register landed in the wrong half");

  COV_READ: cover property (take && req_func == FC_READ ##1 resp_valid && !resp_exception);
  COV_EVENT_ON: cover property (take && dec.sel == SEL_EVENT && req_wdata == EVT_ON ##1 |event_on);
  COV_BAD_VALUE: cover property (resp_valid && resp_data == {8'h00, EXC_ILL_VALUE});

endmodule // chamber_modbus_regs

// ===== tb/modbus_host.sv
`timescale 1ns/100ps
module modbus_host (
  input wire logic clock,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic resp_exception,
  input wire logic [7:0] resp_func,
  input wire logic [15:0] resp_data,
  output logic req_valid,
  output logic req_tcp,
  output logic [7:0] req_station,
  output logic [7:0] req_func,
  output logic [15:0] req_reg,
  output logic [15:0] req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_tcp = 1'b0;
    req_station = 8'h00;
    req_func = 8'h00;
    req_reg = 16'h0000;
    req_wdata = 16'h0000;
  end

  // ==========================================================
  // One request, its answer slot one cycle after the taking edge
  task automatic xfer(input logic tcp, input logic [7:0] stn, input logic [7:0] fc,
                      input logic [15:0] rn, input logic [15:0] wd, output logic got,
                      output logic exc, output logic [7:0] rf, output logic [15:0] rd);
    @(posedge clock);
    req_valid <= 1'b1;
    req_tcp <= tcp;
    req_station <= stn;
    req_func <= fc;
    req_reg <= rn;
    req_wdata <= wd;
    // Hold the request until an edge sees the port ready
    do @(posedge clock); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // Released station, function, register and data fields never keep their last value
    req_station <= ~stn;
    req_func <= ~fc;
    req_reg <= ~rn;
    req_wdata <= ~wd;
    @(posedge clock);
    got = resp_valid;
    exc = resp_exception;
    rf = resp_func;
    rd = resp_data;
  endtask
endmodule // modbus_host

// ===== tb/chamber_modbus_register_map_tb.sv
`timescale 1ns/100ps
module chamber_modbus_register_map_tb import chamber_pkg::*;;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic nv_valid = 1'b0;
  logic [1:0] nv_data_map = MAP_NATIVE;
  logic nv_word_low = 1'b0;
  logic [7:0] nv_station = STATION_DEFAULT;
  baud_t nv_baud = BAUD_SEL_9600;
  parity_t nv_parity = PARITY_NONE;
  logic nv_ip_fixed = 1'b0;
  logic nv_tcp_enable = 1'b1;
  logic [31:0] nv_ip_addr = 32'h0a00_0001;
  logic [31:0] nv_ip_mask = 32'hffff_0000;
  logic [31:0] nv_ip_gateway = 32'h0a00_00fe;
  logic [31:0] meas_temp = 32'h0;
  logic [31:0] meas_hum = 32'h0;
  logic [31:0] work_temp = 32'h0;
  logic [31:0] work_hum = 32'h0;
  logic ramp_active = 1'b0;
  logic req_valid, req_ready, req_tcp, resp_valid, resp_exception, baud_en;
  logic [7:0] req_station, req_func, resp_func, live_station, rf;
  logic [15:0] req_reg, req_wdata, resp_data, temp_ramp_action, temp_ramp_scale, rd;
  logic [31:0] temperature_setpoint, humidity_setpoint, temp_ramp_rate, v, sp_exp;
  logic [31:0] live_ip_addr, live_ip_mask, live_ip_gateway;
  logic [6:0] event_on;
  logic [1:0] live_data_map;
  logic live_word_low, network_addressing_choice, live_tcp_enable, got, exc;
  baud_t live_baud;
  parity_t live_parity;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h0000_0008;
  logic order_low = 1'b0;
  logic use_tcp = 1'b0;
  logic [7:0] stn = STATION_DEFAULT;
  logic [15:0] act_codes [4] = '{ACT_OFF, ACT_STARTUP, ACT_SETPOINT, ACT_BOTH};
  logic [15:0] scale_codes [2] = '{SCALE_MINUTE, SCALE_HOUR};

  chamber_modbus_regs chamber_modbus_regs_inst (.*);
  modbus_host modbus_host_inst (.*);

  always #2.5 clock = ~clock;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] wsel(input logic [31:0] val, input logic hi);
    return (hi ^ order_low) ? val[31:16] : val[15:0];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk(req_ready, 1'b0, "ready while settings load");
    repeat (2) @(posedge clock);
    chk(req_ready, 1'b1, "ready after settings load");
  endtask

  task automatic req(input logic [7:0] fc, input logic [15:0] rn, input logic [15:0] wd);
    modbus_host_inst.xfer(use_tcp, stn, fc, rn, wd, got, exc, rf, rd);
  endtask

  task automatic ok(input logic [7:0] fc, input logic [15:0] rn, input logic [15:0] wd,
                    input logic [15:0] want);
    req(fc, rn, wd);
    chk(got, 1'b1, "answer");
    chk(exc, 1'b0, "exception flag");
    chk(rf, fc, "function echo");
    chk(rd, want, "data word");
  endtask

  task automatic bad(input logic [7:0] fc, input logic [15:0] rn, input logic [15:0] wd,
                     input logic [7:0] code);
    req(fc, rn, wd);
    chk(got, 1'b1, "answer");
    chk(exc, 1'b1, "exception flag");
    chk(rf, fc | FC_EXC_FLAG, "exception function");
    chk(rd, {8'h00, code}, "exception code");
  endtask

  task automatic float_rw(input logic [15:0] rn, input logic [31:0] val);
    ok(FC_WRITE, rn, wsel(val, 1'b0), wsel(val, 1'b0));
    ok(FC_WRITE, rn + 16'h1, wsel(val, 1'b1), wsel(val, 1'b1));
    ok(FC_READ, rn, 16'h0, wsel(val, 1'b0));
    ok(FC_READ, rn + 16'h1, 16'h0, wsel(val, 1'b1));
  endtask

  task automatic float_ro(input logic [15:0] rn, input logic [31:0] val);
    ok(FC_READ, rn, 16'h0, wsel(val, 1'b0));
    ok(FC_READ, rn + 16'h1, 16'h0, wsel(val, 1'b1));
    bad(FC_WRITE, rn, 16'h0, EXC_ILL_ADDR);
  endtask

  task automatic baud_gap(input int want);
    int n;
    n = 0;
    while (baud_en !== 1'b1 && n < 5000) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (baud_en !== 1'b1 && n < 5000);
    chk(n, want, "baud tick spacing");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    do_reset();
    chk(live_data_map, MAP_NATIVE, "map");
    chk(live_word_low, 1'b0, "word order");
    chk(live_station, STATION_DEFAULT, "station");
    chk(live_baud, BAUD_SEL_9600, "baud");
    chk(live_parity, PARITY_NONE, "parity");
    chk(network_addressing_choice, 1'b0, "addressing");
    chk(live_tcp_enable, 1'b1, "tcp");
    chk(live_ip_addr, IP_ADDR_DEFAULT, "ip");
    chk(live_ip_mask, IP_MASK_DEFAULT, "mask");
    chk(live_ip_gateway, IP_GW_DEFAULT, "gateway");
    baud_gap(1302);
    for (int i = 0; i < 7; i++) begin
      ok(FC_READ, REG_EVENT[i], 16'h0, EVT_OFF);
      ok(FC_WRITE, REG_EVENT[i], EVT_ON, EVT_ON);
      chk(event_on[i], 1'b1, "event output");
    end
    bad(FC_WRITE, REG_EVENT[0], 16'h0040, EXC_ILL_VALUE);
    ok(FC_WRITE, REG_EVENT[3], EVT_OFF, EVT_OFF);
    chk(event_on, 7'h77, "event outputs");
    ok(FC_READ, REG_RAMP_ACTION, 16'h0, ACT_OFF);
    ok(FC_READ, REG_RAMP_SCALE, 16'h0, SCALE_MINUTE);
    foreach (act_codes[i]) begin
      ok(FC_WRITE, REG_RAMP_ACTION, act_codes[i], act_codes[i]);
      chk(temp_ramp_action, act_codes[i], "ramp action");
    end
    bad(FC_WRITE, REG_RAMP_ACTION, 16'h0001, EXC_ILL_VALUE);
    foreach (scale_codes[i]) begin
      ok(FC_WRITE, REG_RAMP_SCALE, scale_codes[i], scale_codes[i]);
      chk(temp_ramp_scale, scale_codes[i], "ramp scale");
    end
    bad(FC_WRITE, REG_RAMP_SCALE, 16'h0000, EXC_ILL_VALUE);
    ok(FC_READ, REG_RAMP_SCALE, 16'h0, SCALE_HOUR);
    sp_exp = next_rand();
    float_rw(REG_TEMP_SP, sp_exp);
    chk(temperature_setpoint, sp_exp, "temperature set point");
    v = next_rand();
    float_rw(REG_HUM_SP, v);
    chk(humidity_setpoint, v, "humidity set point");
    v = next_rand();
    float_rw(REG_RAMP_RATE, v);
    chk(temp_ramp_rate, v, "ramp rate");
    float_ro(REG_TEMP_WSP, sp_exp);
    v = next_rand();
    work_temp <= v;
    work_hum <= ~v;
    ramp_active <= 1'b1;
    float_ro(REG_TEMP_WSP, v);
    float_ro(REG_HUM_WSP, ~v);
    v = next_rand();
    meas_temp <= v;
    meas_hum <= ~v;
    float_ro(REG_MEAS_TEMP, v);
    float_ro(REG_MEAS_HUM, ~v);
    bad(FC_READ, REG_TEMP_SP - 16'h1, 16'h0, EXC_ILL_ADDR);
    bad(FC_READ, 16'hffff, 16'h0, EXC_ILL_ADDR);
    bad(8'h10, REG_TEMP_SP, 16'h0, EXC_ILL_FUNC);
    // A foreign station must not see or disturb anything
    stn = 8'h02;
    req(FC_WRITE, REG_RAMP_SCALE, SCALE_MINUTE);
    chk(got, 1'b0, "foreign station answer");
    use_tcp = 1'b1;
    ok(FC_READ, REG_RAMP_SCALE, 16'h0, SCALE_HOUR);
    use_tcp = 1'b0;
    // Stored settings changed while running stay dormant until reset
    nv_valid <= 1'b1;
    nv_word_low <= 1'b1;
    nv_station <= 8'h05;
    nv_baud <= BAUD_SEL_115200;
    nv_parity <= PARITY_EVEN;
    nv_ip_fixed <= 1'b1;
    nv_tcp_enable <= 1'b0;
    repeat (4) @(posedge clock);
    chk(live_word_low, 1'b0, "order before reset");
    chk(live_station, STATION_DEFAULT, "station before reset");
    do_reset();
    chk(live_word_low, 1'b1, "order");
    chk(live_station, 8'h05, "station");
    chk(live_baud, BAUD_SEL_115200, "baud");
    chk(live_parity, PARITY_EVEN, "parity");
    chk(network_addressing_choice, 1'b1, "addressing");
    chk(live_tcp_enable, 1'b0, "tcp");
    chk(live_ip_addr, nv_ip_addr, "ip");
    chk(live_ip_mask, nv_ip_mask, "mask");
    chk(live_ip_gateway, nv_ip_gateway, "gateway");
    baud_gap(CLK_HZ / (OVERSAMPLE * BAUD_115200));
    stn = 8'h05;
    order_low = 1'b1;
    v = next_rand();
    float_rw(REG_TEMP_SP, v);
    chk(temperature_setpoint, v, "swapped set point");
    use_tcp = 1'b1;
    req(FC_READ, REG_TEMP_SP, 16'h0);
    chk(got, 1'b0, "tcp disabled answer");
    use_tcp = 1'b0;
    nv_data_map <= MAP_LEGACY;
    nv_station <= 8'hf8;
    do_reset();
    stn = STATION_DEFAULT;
    chk(live_station, STATION_DEFAULT, "station out of range");
    chk(live_data_map, MAP_LEGACY, "map");
    bad(FC_READ, REG_TEMP_SP, 16'h0, EXC_ILL_ADDR);
    bad(FC_WRITE, REG_EVENT[0], EVT_ON, EXC_ILL_ADDR);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    close_out();
  end
endmodule // chamber_modbus_register_map_tb
